/* File: testbench.sv */
`timescale 1ns/10ps

`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module testbench;
  import upf_pkg::*;

  // ==========================================
  // Signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic stp = 1'b0;
  logic fault = 1'b0;
  logic avbus = 1'b0;
  logic alt_exit = 1'b0;
  wire link_clk;
  wire wr;
  wire rd;
  wire [5:0] addr;
  wire [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] func_out;
  logic [7:0] intf_out;
  upf_phy_ctl_type phy;
  upf_intf_ctl_type intf;
  int failures = 0;
  int n_tests = 0;
  logic [5:0] base [2] = '{6'h04, 6'h07};
  // one alternative mode bit at most
  logic [23:0] cs [6] = '{{8'h41, 8'h02, 8'h00}, {8'h41, 8'h0a, 8'h01},
    {8'h41, 8'h01, 8'h00}, {8'h41, 8'h00, 8'h01}, {8'h01, 8'h02, 8'h01},
    {8'h41, 8'h04, 8'h00}};

  always #5 mclk = ~mclk;

  // ==========================================
  // Instances
  upf_link_model link (
    .mclk_in(mclk), .link_clk_out(link_clk), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .data_out(wdata));

  upf_ctrl uut (
    .mclk_in(mclk), .rst_in(rst), .link_clk_in(link_clk),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .stp_in(stp),
    .fault_in(fault), .a_vbus_valid_in(avbus), .alt_mode_exit_in(alt_exit),
    .phy_ctl_out(phy), .intf_ctl_out(intf),
    .phy_function_control_out(func_out),
    .phy_interface_control_out(intf_out));

  // ==========================================
  // Tasks
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    link.access(1'b1, a, d, 1);
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, input logic [7:0] e);
    link.access(1'b0, a, 8'h00, 6);
    `CHK(rdata, e)
  endtask : rd_reg

  task automatic settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask : settle

  task automatic end_of_test;
    $display("Comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #300000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      rd_reg(6'h04 + 6'(i), 8'h41);
      rd_reg(6'h07 + 6'(i), 8'h00);
    end
    foreach (base[i]) begin
      wr_reg(base[i], 8'h91);
      rd_reg(base[i], 8'h91);
      wr_reg(base[i] + 6'h01, 8'h60);
      rd_reg(base[i] + 6'h02, 8'hf1);
      wr_reg(base[i] + 6'h02, 8'hc0);
      rd_reg(base[i] + 6'h01, 8'h31);
    end
    wr_reg(6'h0a, 8'hff);
    rd_reg(6'h0a, 8'h00);
    rd_reg(6'h07, 8'h31);
    for (int op = 0; op < 4; op++)
      for (int x = 0; x < 4; x++)
        for (int t = 0; t < 2; t++) begin
          if (op == 3 && x != 0) continue;
          wr_reg(6'h04, {3'b010, 2'(op), 1'(t), 2'(x)});
          settle();
          `CHK(phy.hs_xcvr_en, 1'(x == 0))
          `CHK(phy.fs_preamble_en, 1'(x == 3))
          `CHK(phy.tx_drive_en, 1'(op != 1))
          `CHK(phy.tx_stuff_nrzi_en, 1'(op == 0 || op == 3))
          `CHK(phy.tx_sync_eop_en, 1'(op != 3))
          `CHK(phy.hs_term_en, 1'(t == 0 && x == 0 && op != 1))
          `CHK(phy.plus_pullup_en, 1'(t && x != 2 && (x || op == 2)))
          `CHK(phy.minus_pullup_en, 1'(t == 1 && x == 2))
          `CHK(phy.fs_xcvr_en, 1'(x == 1 || x == 3))
          `CHK(phy.ls_xcvr_en, 1'(x == 2))
        end
    wr_reg(6'h07, 8'h00);
    for (int s = 0; s < 2; s++) begin
      stp = 1'(s);
      settle();
      `CHK(intf.stp_pullup_en, 1'b1)
      `CHK(intf.data_pulldown_en, 1'(s))
      `CHK(intf.link_released, 1'(s))
    end
    wr_reg(6'h08, 8'h80);
    settle();
    `CHK(intf.stp_pullup_en, 1'b0)
    `CHK(intf.data_pulldown_en, 1'b0)
    stp = 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr_reg(6'h07, {1'b0, 2'(m), 5'h00});
      for (int p = 0; p < 4; p++) begin
        fault = p[0];
        avbus = p[1];
        settle();
        `CHK(intf.bus_voltage_state, (p[0] ^ m[0]) & (m[1] | p[1]))
      end
    end
    foreach (cs[i]) begin
      wr_reg(6'h04, cs[i][23:16]);
      wr_reg(6'h07, cs[i][15:8]);
      settle();
      `CHK(intf.clock_powered, cs[i][0])
      `CHK(intf.three_pin_serial_mode, cs[i][9])
      `CHK(intf.six_pin_serial_mode, cs[i][8])
      `CHK(func_out, cs[i][23:16])
    end
    wr_reg(6'h07, 8'h24);
    settle();
    `CHK(intf.carkit_mode, 1'b1)
    alt_exit = 1'b1;
    @(posedge mclk);
    #1;
    alt_exit = 1'b0;
    settle();
    `CHK(intf.carkit_mode, 1'b0)
    rd_reg(6'h07, 8'h20);
    `CHK(intf_out, 8'h20)
    end_of_test();
  end

endmodule : testbench

/* File: upf_ctrl.sv */
`timescale 1ns/10ps

// Contract
// - Encoding mode field selects transmit encoding style
// - Termination select drives pull-up and HS terminations
// - Speed select field enables one transceiver
// - Speed 11b prefixes full-speed preamble
// - Function control write, set, clear addresses
// - Interface control write, set, clear addresses
// - Interface control resets zero, fixed bit layout
// - Protection: stop pull-up, data pull-downs
// - Protection detects link releasing stop
// - Protect disable removes all weak resistors
// - Complement bit inverts fault input
// - Pass-through skips bus-valid qualification
// - Clock suspend powers down clock only
// - Clock suspend honoured only serial or carkit, powered
// - Clock suspend one keeps clock powered
// - Set address ORs, clear address masks
// - Alternative mode bits self-clear on exit
module upf_ctrl
  import upf_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // ULPI register port, timed by the link clock
  input wire logic link_clk_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Interface pins and analog status
  input wire logic stp_in,
  input wire logic fault_in,
  input wire logic a_vbus_valid_in,
  input wire logic alt_mode_exit_in,
  // Controls to the analog front end
  output upf_phy_ctl_type phy_ctl_out,
  output upf_intf_ctl_type intf_ctl_out,
  output logic [7:0] phy_function_control_out,
  output logic [7:0] phy_interface_control_out
);

  // ==========================================================================
  // Elaboration checks
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // ==========================================================================
  // Input synchronisers
  upf_pins_type pins_raw;
  upf_pins_type sync_q [SYNC_STAGES];
  upf_pins_type pins_s;
  logic link_clk_prev_q;
  logic link_edge;

  assign pins_raw = '{link_clk: link_clk_in, wr: reg_wr_in, rd: reg_rd_in,
                      addr: reg_addr_in, data: reg_wdata_in, stp: stp_in,
                      fault: fault_in, a_vbus_valid: a_vbus_valid_in,
                      alt_exit: alt_mode_exit_in};

  for (genvar i = 0; i < SYNC_STAGES; i++) begin : g_sync
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        sync_q[i] <= '0;
      end else begin
        sync_q[i] <= (i == 0) ? pins_raw : sync_q[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign pins_s = sync_q[SYNC_STAGES-1];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      link_clk_prev_q <= 1'b0;
    end else begin
      link_clk_prev_q <= pins_s.link_clk;
    end
  end

  // Register port acts on the rising edge of the link clock
  assign link_edge = pins_s.link_clk && !link_clk_prev_q;

  // ==========================================================================
  // Register access decode
  function automatic logic [7:0] upf_update(
    input logic [7:0] cur,
    input logic [7:0] data,
    input logic [5:0] addr,
    input logic [5:0] base
  );
    logic [7:0] res;
    res = cur;
    if (addr == base) begin
      res = data;
    end else if (addr == base + 6'h01) begin
      res = cur | data;
    end else if (addr == base + 6'h02) begin
      res = cur & ~data;
    end
    return res;
  endfunction : upf_update

  function automatic logic in_range(
    input logic [5:0] addr,
    input logic [5:0] base
  );
    return (addr >= base) && (addr <= base + 6'h02);
  endfunction : in_range

  logic acc_wr;
  logic acc_rd;
  logic hit_func;
  logic hit_intf;
  logic [7:0] func_q;
  logic [7:0] func_d;
  logic [7:0] intf_q;
  logic [7:0] intf_d;
  logic [7:0] intf_wr;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  assign acc_wr = link_edge && pins_s.wr;
  assign acc_rd = link_edge && pins_s.rd;
  assign hit_func = in_range(pins_s.addr, UPF_FUNC_WR_ADDR);
  assign hit_intf = in_range(pins_s.addr, UPF_INTF_WR_ADDR);

  // OR on set, mask on clear
  // reserved bit 7 stored as written
  assign func_d = (acc_wr && hit_func) ?
    upf_update(func_q, pins_s.data, pins_s.addr, UPF_FUNC_WR_ADDR) : func_q;

  assign intf_wr = (acc_wr && hit_intf) ?
    upf_update(intf_q, pins_s.data, pins_s.addr, UPF_INTF_WR_ADDR) : intf_q;

  // mode exit clears alt bits, an interface control write in the same cycle wins
  assign intf_d = (pins_s.alt_exit && !(acc_wr && hit_intf)) ?
    (intf_wr & ~UPF_ALT_MODE_MASK) : intf_wr;

  assign rdata_d = !acc_rd ? rdata_q :
    hit_func ? func_q :
    hit_intf ? intf_q : 8'h00;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      func_q <= UPF_FUNC_RESET;
      intf_q <= UPF_INTF_RESET;
      rdata_q <= 8'h00;
    end else begin
      func_q <= func_d;
      intf_q <= intf_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Function control decode
  upf_enc_type enc_mode;
  upf_xcvr_type xcvr_sel;
  logic termination_select;
  logic phy_suspend_n;
  logic host_pulldowns;
  upf_phy_ctl_type phy_d;
  upf_phy_ctl_type phy_q;

  assign enc_mode = upf_enc_type'(func_q[UPF_F_ENC_MODE_LO +: 2]);
  assign xcvr_sel = upf_xcvr_type'(func_q[UPF_F_XCVR_LO +: 2]);
  assign termination_select = func_q[UPF_F_TERMSEL];
  assign phy_suspend_n = func_q[UPF_F_SUSPEND_N];
  // Pull-down enables live in the OTG register; taken as off here
  assign host_pulldowns = 1'b0;

  assign phy_d.hs_xcvr_en = (xcvr_sel == UPF_XCVR_HS);
  assign phy_d.fs_xcvr_en = (xcvr_sel == UPF_XCVR_FS) ||
                            (xcvr_sel == UPF_XCVR_FS_LS);
  assign phy_d.ls_xcvr_en = (xcvr_sel == UPF_XCVR_LS);
  assign phy_d.fs_preamble_en = (xcvr_sel == UPF_XCVR_FS_LS);
  assign phy_d.tx_drive_en = (enc_mode != UPF_ENC_NON_DRIVING);
  assign phy_d.tx_stuff_nrzi_en = (enc_mode == UPF_ENC_NORMAL) ||
                                  (enc_mode == UPF_ENC_NO_SYNC_EOP);
  // 11b only ever seen with high-speed packets
  assign phy_d.tx_sync_eop_en = (enc_mode != UPF_ENC_NO_SYNC_EOP);
  // terminations from speed, mode, select and pull-downs
  assign phy_d.hs_term_en = !termination_select &&
                            (xcvr_sel == UPF_XCVR_HS) &&
                            (enc_mode != UPF_ENC_NON_DRIVING);
  assign phy_d.plus_pullup_en = termination_select && !host_pulldowns &&
    (xcvr_sel != UPF_XCVR_LS) &&
    ((xcvr_sel != UPF_XCVR_HS) || (enc_mode == UPF_ENC_NO_STUFF));
  assign phy_d.minus_pullup_en = termination_select && !host_pulldowns &&
    (xcvr_sel == UPF_XCVR_LS);

  // ==========================================================================
  // Interface control decode
  logic serial_mode;
  logic clk_susp_honoured;
  logic complement;
  upf_intf_ctl_type intf_ctl_d;
  upf_intf_ctl_type intf_ctl_q;

  assign serial_mode = intf_q[UPF_I_SERIAL3] || intf_q[UPF_I_SERIAL6];
  // honoured only in a serial or UART mode while powered
  assign clk_susp_honoured = (serial_mode || intf_q[UPF_I_CARKIT]) &&
                             phy_suspend_n;
  assign complement = pins_s.fault ^ intf_q[UPF_I_COMPL];

  // weak pull-up on stop while protected
  assign intf_ctl_d.stp_pullup_en = !intf_q[UPF_I_PROT_DIS];
  assign intf_ctl_d.data_pulldown_en = !intf_q[UPF_I_PROT_DIS] && pins_s.stp;
  // stop pulled high means the link let go of it
  assign intf_ctl_d.link_released = !intf_q[UPF_I_PROT_DIS] && pins_s.stp;
  // optional qualification with the bus-valid comparator
  assign intf_ctl_d.bus_voltage_state = complement &&
    (intf_q[UPF_I_PASS_THRU] || pins_s.a_vbus_valid);
  // clock power alone follows the suspend bit
  assign intf_ctl_d.clock_powered = !clk_susp_honoured ||
                                    intf_q[UPF_I_CLK_SUSP_N];
  // several at once is left undefined
  assign intf_ctl_d.carkit_mode = intf_q[UPF_I_CARKIT];
  assign intf_ctl_d.three_pin_serial_mode = intf_q[UPF_I_SERIAL3];
  assign intf_ctl_d.six_pin_serial_mode = intf_q[UPF_I_SERIAL6];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_q <= '0;
      intf_ctl_q <= '0;
    end else begin
      phy_q <= phy_d;
      intf_ctl_q <= intf_ctl_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_out = rdata_q;
  assign phy_ctl_out = phy_q;
  assign intf_ctl_out = intf_ctl_q;
  assign phy_function_control_out = func_q;
  assign phy_interface_control_out = intf_q;

  // ==========================================================================
  // Assertions
  property p_func_write;
    @(posedge mclk_in) disable iff (rst_in)
    acc_wr && pins_s.addr == UPF_FUNC_WR_ADDR |=> func_q == $past(pins_s.data);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("function control write not stored");

  property p_func_set;
    @(posedge mclk_in) disable iff (rst_in)
    acc_wr && pins_s.addr == UPF_FUNC_SET_ADDR |=>
      func_q == ($past(func_q) | $past(pins_s.data));
  endproperty
  a_func_set: assert property (p_func_set)
    else $error("function control set wrong");

  property p_intf_clear;
    @(posedge mclk_in) disable iff (rst_in)
    acc_wr && pins_s.addr == UPF_INTF_CLR_ADDR |=>
      intf_q[7:3] == ($past(intf_q[7:3]) & ~$past(pins_s.data[7:3]));
  endproperty
  a_intf_clear: assert property (p_intf_clear)
    else $error("interface control clear wrong");

  property p_alt_exit;
    @(posedge mclk_in) disable iff (rst_in)
    pins_s.alt_exit && !(acc_wr && hit_intf) |=> intf_q[2:0] == 3'b000;
  endproperty
  a_alt_exit: assert property (p_alt_exit)
    else $error("alternative mode bit not cleared on exit");

  property p_protect_off;
    @(posedge mclk_in) disable iff (rst_in)
    intf_q[UPF_I_PROT_DIS] ##1 intf_q[UPF_I_PROT_DIS] |->
      !intf_ctl_out.stp_pullup_en && !intf_ctl_out.data_pulldown_en;
  endproperty
  a_protect_off: assert property (p_protect_off)
    else $error("weak resistors left on with protection disabled");

  property p_protect_on;
    @(posedge mclk_in) disable iff (rst_in)
    !intf_q[UPF_I_PROT_DIS] && pins_s.stp |=>
      intf_ctl_out.data_pulldown_en && intf_ctl_out.link_released;
  endproperty
  a_protect_on: assert property (p_protect_on)
    else $error("data pull-downs missing with stop high");

  property p_indicator;
    @(posedge mclk_in) disable iff (rst_in)
    1'b1 |=> intf_ctl_out.bus_voltage_state ==
      (($past(pins_s.fault) ^ $past(intf_q[UPF_I_COMPL])) &&
       ($past(intf_q[UPF_I_PASS_THRU]) || $past(pins_s.a_vbus_valid)));
  endproperty
  a_indicator: assert property (p_indicator)
    else $error("bus voltage state wrong");

  property p_preamble;
    @(posedge mclk_in) disable iff (rst_in)
    xcvr_sel == UPF_XCVR_FS_LS |=>
      phy_ctl_out.fs_preamble_en && phy_ctl_out.fs_xcvr_en;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble not enabled");

  property p_non_driving;
    @(posedge mclk_in) disable iff (rst_in)
    enc_mode == UPF_ENC_NON_DRIVING |=> !phy_ctl_out.tx_drive_en;
  endproperty
  a_non_driving: assert property (p_non_driving)
    else $error("transmitter driving in non-driving mode");

  property p_clock_ignored;
    @(posedge mclk_in) disable iff (rst_in)
    !(serial_mode || intf_q[UPF_I_CARKIT]) |=> intf_ctl_out.clock_powered;
  endproperty
  a_clock_ignored: assert property (p_clock_ignored)
    else $error("clock suspend honoured outside serial mode");

  c_set_write: cover property (@(posedge mclk_in) disable iff (rst_in)
    acc_wr && pins_s.addr == UPF_INTF_SET_ADDR);
  c_serial_exit: cover property (@(posedge mclk_in) disable iff (rst_in)
    serial_mode ##1 pins_s.alt_exit);
  c_clock_off: cover property (@(posedge mclk_in) disable iff (rst_in)
    !intf_ctl_out.clock_powered);

endmodule : upf_ctrl

/* File: upf_link_model.sv */
`timescale 1ns/10ps

// ==========================================
// Link side of the register port
module upf_link_model (
  // Clock
  input wire logic mclk_in,
  // Register port toward the device
  output logic link_clk_out,
  output logic wr_out,
  output logic rd_out,
  output logic [5:0] addr_out,
  output logic [7:0] data_out
);

  initial begin
    link_clk_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 6'h3f;
    data_out = 8'hff;
  end

  // One access framed by a single 160 ns link clock period.
  // The link clock stands still low between accesses.
  task automatic access(input logic wr, input logic [5:0] addr,
                        input logic [7:0] data, input int gap);
    repeat (gap) @(posedge mclk_in);
    #1;
    wr_out = wr;
    rd_out = !wr;
    addr_out = addr;
    data_out = data;
    repeat (8) @(posedge mclk_in);
    #1;
    link_clk_out = 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
    link_clk_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    // Released lines show the inverse of the last value
    addr_out = ~addr;
    data_out = ~data;
  endtask : access

endmodule : upf_link_model

/* File: upf_pkg.sv */
package upf_pkg;

  // ==========================================================================
  // Register addresses on the ULPI register port
  localparam logic [5:0] UPF_FUNC_WR_ADDR = 6'h04;
  localparam logic [5:0] UPF_FUNC_SET_ADDR = 6'h05;
  localparam logic [5:0] UPF_FUNC_CLR_ADDR = 6'h06;
  localparam logic [5:0] UPF_INTF_WR_ADDR = 6'h07;
  localparam logic [5:0] UPF_INTF_SET_ADDR = 6'h08;
  localparam logic [5:0] UPF_INTF_CLR_ADDR = 6'h09;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] UPF_FUNC_RESET = 8'h41;
  localparam logic [7:0] UPF_INTF_RESET = 8'h00;

  // ==========================================================================
  // Function control field positions
  localparam int UPF_F_SUSPEND_N = 6;
  localparam int UPF_F_ENC_MODE_LO = 3;
  localparam int UPF_F_TERMSEL = 2;
  localparam int UPF_F_XCVR_LO = 0;

  // ==========================================================================
  // Interface control field positions
  localparam int UPF_I_PROT_DIS = 7;
  localparam int UPF_I_PASS_THRU = 6;
  localparam int UPF_I_COMPL = 5;
  localparam int UPF_I_CLK_SUSP_N = 3;
  localparam int UPF_I_CARKIT = 2;
  localparam int UPF_I_SERIAL3 = 1;
  localparam int UPF_I_SERIAL6 = 0;
  localparam logic [7:0] UPF_ALT_MODE_MASK = 8'h07;

  // ==========================================================================
  // Mode encodings
  typedef enum logic [1:0] {
    UPF_ENC_NORMAL = 2'b00,
    UPF_ENC_NON_DRIVING = 2'b01,
    UPF_ENC_NO_STUFF = 2'b10,
    UPF_ENC_NO_SYNC_EOP = 2'b11
  } upf_enc_type;

  typedef enum logic [1:0] {
    UPF_XCVR_HS = 2'b00,
    UPF_XCVR_FS = 2'b01,
    UPF_XCVR_LS = 2'b10,
    UPF_XCVR_FS_LS = 2'b11
  } upf_xcvr_type;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic link_clk;
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] data;
    logic stp;
    logic fault;
    logic a_vbus_valid;
    logic alt_exit;
  } upf_pins_type;

  typedef struct packed {
    logic hs_xcvr_en;
    logic fs_xcvr_en;
    logic ls_xcvr_en;
    logic fs_preamble_en;
    logic tx_drive_en;
    logic tx_stuff_nrzi_en;
    logic tx_sync_eop_en;
    logic hs_term_en;
    logic plus_pullup_en;
    logic minus_pullup_en;
  } upf_phy_ctl_type;

  typedef struct packed {
    logic stp_pullup_en;
    logic data_pulldown_en;
    logic link_released;
    logic bus_voltage_state;
    logic clock_powered;
    logic carkit_mode;
    logic three_pin_serial_mode;
    logic six_pin_serial_mode;
  } upf_intf_ctl_type;

endpackage : upf_pkg
